// ==== dds_latency_pkg.sv ====
// Constants, types and register map of the tuning-word latency pipeline
// Contract
// - Single tone: frequency 222/238, phase 206/222 cycles
// - Parallel modulation: same, amplitude 78 with keying
// - Matched latency aligns phase, amplitude to frequency
// - Sweep: frequency 238/254, phase 222/238, amplitude 94
// - Sweep matched: all channels 238, or 254 keyed
package dds_latency_pkg;

  // Operating modes
  typedef enum logic [1:0] {MODE_SINGLE, MODE_PROFILE, MODE_PARALLEL, MODE_SWEEP} mode_t;

  // Word widths
  localparam int FREQ_W = 32;
  localparam int PHASE_W = 16;
  localparam int AMP_W = 12;
  localparam int PORT_W = 32;
  localparam int FSEL_W = 4;
  localparam int PROF_W = 3;

  // Delay line geometry
  localparam int DEPTH = 256;
  localparam int PTR_W = 8;

  // Register byte offsets
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_FREQ = 8'h04;
  localparam logic [7:0] ADR_PHASE = 8'h08;
  localparam logic [7:0] ADR_AMP = 8'h0C;
  localparam logic [7:0] ADR_STATUS = 8'h10;
  localparam logic [7:0] ADR_FREQ_OUT = 8'h14;
  localparam logic [7:0] ADR_PHASE_OUT = 8'h18;
  localparam logic [7:0] ADR_AMP_OUT = 8'h1C;
  localparam logic [7:0] ADR_LATENCY = 8'h20;

  // Control field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_KEY_BIT = 2;
  localparam int CTRL_MATCH_BIT = 3;
  localparam int CTRL_COMMIT_BIT = 4;

  // Status field positions
  localparam int STAT_PROF_LSB = 0;
  localparam int STAT_RDIR_BIT = 3;
  localparam int STAT_RPAUSE_BIT = 4;
  localparam int STAT_FSEL_LSB = 8;

  // Latency register field positions
  localparam int LATREG_FREQ_LSB = 0;
  localparam int LATREG_PHASE_LSB = 8;
  localparam int LATREG_AMP_LSB = 16;

  // Function select codes for port routing
  localparam logic [3:0] FSEL_FREQ = 4'h0;
  localparam logic [3:0] FSEL_PHASE = 4'h1;
  localparam logic [3:0] FSEL_AMP = 4'h2;

  // Channel selectors for the latency lookup
  localparam logic [1:0] CH_FREQ = 2'h0;
  localparam logic [1:0] CH_PHASE = 2'h1;
  localparam logic [1:0] CH_AMP = 2'h2;

  // Pipeline delays in core sample clock cycles
  localparam logic [7:0] FREQ_LAT_BASE = 8'hDE;
  localparam logic [7:0] FREQ_LAT_KEY = 8'hEE;
  localparam logic [7:0] FREQ_LAT_SWEEP = 8'hEE;
  localparam logic [7:0] FREQ_LAT_SWEEP_KEY = 8'hFE;
  localparam logic [7:0] PHASE_LAT_BASE = 8'hCE;
  localparam logic [7:0] PHASE_LAT_KEY = 8'hDE;
  localparam logic [7:0] PHASE_LAT_SWEEP = 8'hDE;
  localparam logic [7:0] PHASE_LAT_SWEEP_KEY = 8'hEE;
  localparam logic [7:0] AMP_LAT = 8'h4E;
  localparam logic [7:0] AMP_LAT_SWEEP = 8'h5E;

  // Reset values and the age saturation limit
  localparam logic [FREQ_W-1:0] FREQ_RST = 32'h0000_0000;
  localparam logic [PHASE_W-1:0] PHASE_RST = 16'h0000;
  localparam logic [AMP_W-1:0] AMP_FULL = 12'hFFF;
  localparam logic [7:0] AGE_MAX = 8'hFF;

endpackage

// ==== dds_tuning_latency_pipeline.sv ====
// Tuning-word latency pipeline with Wishbone registers and parallel port
//
// Chosen here: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
module dds_tuning_latency_pipeline
  import dds_latency_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Parallel port
  input wire logic [PORT_W-1:0] port_data,
  input wire logic [FSEL_W-1:0] func_sel,
  input wire logic commit_strobe,
  input wire logic [PROF_W-1:0] profile_sel,
  input wire logic ramp_direction_control,
  input wire logic ramp_pause,
  // Delayed tuning words
  output logic [FREQ_W-1:0] freq_out,
  output logic [PHASE_W-1:0] phase_out,
  output logic [AMP_W-1:0] amp_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Delay for one channel under the current configuration
  function automatic logic [7:0] lat_sel(input logic [1:0] ch, input mode_t m,
                                         input logic key, input logic match);
    logic [7:0] f;
    logic [7:0] d;
    f = (m == MODE_SWEEP) ? (key ? FREQ_LAT_SWEEP_KEY : FREQ_LAT_SWEEP) :
                            (key ? FREQ_LAT_KEY : FREQ_LAT_BASE);
    if (ch == CH_FREQ || match) begin
      d = f;
    end else if (ch == CH_PHASE) begin
      d = (m == MODE_SWEEP) ? (key ? PHASE_LAT_SWEEP_KEY : PHASE_LAT_SWEEP) :
                              (key ? PHASE_LAT_KEY : PHASE_LAT_BASE);
    end else begin
      d = (m == MODE_SWEEP) ? AMP_LAT_SWEEP : AMP_LAT;
    end
    return d;
  endfunction

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Port capture

  logic [PORT_W-1:0] port_q; // Captured data bus
  logic [FSEL_W-1:0] fsel_q; // Captured function select
  logic commit_q; // Captured commit strobe
  logic [PROF_W-1:0] prof_q; // Captured profile select
  logic rdir_q; // Captured ramp direction
  logic rpause_q; // Captured ramp pause

  // All port pins land in flops on the edge, no logic reads them raw; only the assertions read func_sel and port_data raw
  always_ff @(posedge clk) begin
    if (srst) begin
      port_q <= '0;
      fsel_q <= '0;
      commit_q <= 1'b0;
      prof_q <= '0;
      rdir_q <= 1'b0;
      rpause_q <= 1'b0;
    end else begin
      port_q <= port_data;
      fsel_q <= func_sel;
      commit_q <= commit_strobe;
      prof_q <= profile_sel;
      rdir_q <= ramp_direction_control;
      rpause_q <= ramp_pause;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone registers

  mode_t mode; // Operating mode
  logic key_en; // Amplitude keying on
  logic match_en; // Matched latency on
  logic [FREQ_W-1:0] stage_freq; // Staged frequency word
  logic [PHASE_W-1:0] stage_phase; // Staged phase word
  logic [AMP_W-1:0] stage_amp; // Staged amplitude word
  mode_t next_mode;
  logic next_key_en;
  logic next_match_en;
  logic [FREQ_W-1:0] next_stage_freq;
  logic [PHASE_W-1:0] next_stage_phase;
  logic [AMP_W-1:0] next_stage_amp;
  logic next_ack;
  logic [31:0] next_dat;
  logic wr_fire; // Write lands at the ack edge
  logic ctrl_wr; // Low control byte written
  logic sw_commit; // Software commit pulse
  logic [7:0] lat_f; // Current frequency delay
  logic [7:0] lat_p; // Current phase delay
  logic [7:0] lat_a; // Current amplitude delay

  assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign ctrl_wr = wr_fire && (wb_adr_i == ADR_CTRL) && wb_sel_i[0];
  assign sw_commit = ctrl_wr && wb_dat_i[CTRL_COMMIT_BIT];
  assign lat_f = lat_sel(CH_FREQ, mode, key_en, match_en);
  assign lat_p = lat_sel(CH_PHASE, mode, key_en, match_en);
  assign lat_a = lat_sel(CH_AMP, mode, key_en, match_en);

  // Decode, byte-lane writes and read mux
  always_comb begin
    logic [31:0] tmp;
    tmp = '0;
    next_mode = mode;
    next_key_en = key_en;
    next_match_en = match_en;
    next_stage_freq = stage_freq;
    next_stage_phase = stage_phase;
    next_stage_amp = stage_amp;
    // Ack one cycle after the request, dropped the cycle after
    next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
    next_dat = wb_dat_o;
    if (ctrl_wr) begin
      next_mode = mode_t'(wb_dat_i[CTRL_MODE_LSB +: 2]);
      next_key_en = wb_dat_i[CTRL_KEY_BIT];
      next_match_en = wb_dat_i[CTRL_MATCH_BIT];
    end
    if (wr_fire && wb_adr_i == ADR_FREQ) begin
      next_stage_freq = merge(stage_freq, wb_dat_i, wb_sel_i);
    end
    if (wr_fire && wb_adr_i == ADR_PHASE) begin
      tmp = merge(32'(stage_phase), wb_dat_i, wb_sel_i);
      next_stage_phase = tmp[PHASE_W-1:0];
    end
    if (wr_fire && wb_adr_i == ADR_AMP) begin
      tmp = merge(32'(stage_amp), wb_dat_i, wb_sel_i);
      next_stage_amp = tmp[AMP_W-1:0];
    end
    // Read data is loaded on the same edge that raises ack
    if (next_ack) begin
      next_dat = '0;
      case (wb_adr_i)
        ADR_CTRL: begin
          next_dat[CTRL_MODE_LSB +: 2] = mode;
          next_dat[CTRL_KEY_BIT] = key_en;
          next_dat[CTRL_MATCH_BIT] = match_en;
        end
        ADR_FREQ: next_dat = stage_freq;
        ADR_PHASE: next_dat = 32'(stage_phase);
        ADR_AMP: next_dat = 32'(stage_amp);
        ADR_STATUS: begin
          next_dat[STAT_PROF_LSB +: PROF_W] = prof_q;
          next_dat[STAT_RDIR_BIT] = rdir_q;
          next_dat[STAT_RPAUSE_BIT] = rpause_q;
          next_dat[STAT_FSEL_LSB +: FSEL_W] = fsel_q;
        end
        ADR_FREQ_OUT: next_dat = freq_out;
        ADR_PHASE_OUT: next_dat = 32'(phase_out);
        ADR_AMP_OUT: next_dat = 32'(amp_out);
        ADR_LATENCY: begin
          next_dat[LATREG_FREQ_LSB +: 8] = lat_f;
          next_dat[LATREG_PHASE_LSB +: 8] = lat_p;
          next_dat[LATREG_AMP_LSB +: 8] = lat_a;
        end
        // Unmapped offsets ack and read zero
        default: next_dat = '0;
      endcase
    end
  end

  // Register file flops
  always_ff @(posedge clk) begin
    if (srst) begin
      mode <= MODE_SINGLE;
      key_en <= 1'b0;
      match_en <= 1'b0;
      stage_freq <= FREQ_RST;
      stage_phase <= PHASE_RST;
      stage_amp <= AMP_FULL;
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      mode <= next_mode;
      key_en <= next_key_en;
      match_en <= next_match_en;
      stage_freq <= next_stage_freq;
      stage_phase <= next_stage_phase;
      stage_amp <= next_stage_amp;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source words entering the pipeline

  logic [FREQ_W-1:0] freq_src; // Frequency word at pipeline input
  logic [PHASE_W-1:0] phase_src; // Phase word at pipeline input
  logic [AMP_W-1:0] amp_src; // Amplitude word at pipeline input
  logic [PTR_W-1:0] wptr; // Delay line write pointer
  logic [7:0] cfg_age; // Cycles since last control write
  logic [FREQ_W-1:0] next_freq_src;
  logic [PHASE_W-1:0] next_phase_src;
  logic [AMP_W-1:0] next_amp_src;
  logic [7:0] next_cfg_age;
  logic par_mode; // Port feeds words directly

  assign par_mode = (mode == MODE_PARALLEL);

  // Commit moves staged words in; in parallel mode the port wins per channel
  always_comb begin
    next_freq_src = freq_src;
    next_phase_src = phase_src;
    next_amp_src = amp_src;
    if (sw_commit || commit_q) begin
      next_freq_src = stage_freq;
      next_phase_src = stage_phase;
      next_amp_src = stage_amp;
    end
    if (par_mode) begin
      case (fsel_q)
        FSEL_FREQ: next_freq_src = port_q[FREQ_W-1:0];
        FSEL_PHASE: next_phase_src = port_q[PHASE_W-1:0];
        FSEL_AMP: next_amp_src = port_q[AMP_W-1:0];
        // Other codes leave the words alone
        default: next_freq_src = next_freq_src;
      endcase
    end
    // Age saturates; a control write restarts it
    next_cfg_age = ctrl_wr ? 8'h00 : ((cfg_age == AGE_MAX) ? cfg_age : cfg_age + 8'h01);
  end

  // Source flops
  always_ff @(posedge clk) begin
    if (srst) begin
      freq_src <= FREQ_RST;
      phase_src <= PHASE_RST;
      amp_src <= AMP_FULL;
      wptr <= '0;
      cfg_age <= 8'h00;
    end else begin
      freq_src <= next_freq_src;
      phase_src <= next_phase_src;
      amp_src <= next_amp_src;
      wptr <= wptr + 8'h01;
      cfg_age <= next_cfg_age;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Delay lines and outputs

  logic [FREQ_W-1:0] freq_mem [DEPTH]; // Frequency history
  logic [PHASE_W-1:0] phase_mem [DEPTH]; // Phase history
  logic [AMP_W-1:0] amp_mem [DEPTH]; // Amplitude history
  logic [FREQ_W-1:0] next_freq_out;
  logic [PHASE_W-1:0] next_phase_out;
  logic [AMP_W-1:0] next_amp_out;

  // Tap at delay minus one, the output flop adds the last cycle;
  // a mode change mid-flight re-taps history, so words may repeat or skip
  always_comb begin
    next_freq_out = freq_mem[wptr - lat_f + 8'h01];
    next_phase_out = phase_mem[wptr - lat_p + 8'h01];
    // Without keying the amplitude path is bypassed at full scale
    next_amp_out = key_en ? amp_mem[wptr - lat_a + 8'h01] : AMP_FULL;
  end

  // History is not reset; outputs are
  always_ff @(posedge clk) begin
    freq_mem[wptr] <= freq_src;
    phase_mem[wptr] <= phase_src;
    amp_mem[wptr] <= amp_src;
    if (srst) begin
      freq_out <= FREQ_RST;
      phase_out <= PHASE_RST;
      amp_out <= AMP_FULL;
    end else begin
      freq_out <= next_freq_out;
      phase_out <= next_phase_out;
      amp_out <= next_amp_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence settled_s;
    cfg_age == AGE_MAX;
  endsequence

  sequence plain_s;
    mode != MODE_SWEEP && !match_en;
  endsequence

  sequence par_freq_s;
    (par_mode && func_sel == FSEL_FREQ) ##1 par_mode;
  endsequence

  freq_single_a: assert property (settled_s and plain_s and !key_en |->
    freq_out == $past(freq_src, FREQ_LAT_BASE)) else $error("frequency delay wrong");
  phase_keyed_a: assert property (settled_s and plain_s and key_en |->
    phase_out == $past(phase_src, PHASE_LAT_KEY)) else $error("keyed phase delay wrong");
  amp_plain_a: assert property (settled_s and plain_s and key_en |->
    amp_out == $past(amp_src, AMP_LAT)) else $error("amplitude delay wrong");
  match_align_a: assert property (settled_s and mode != MODE_SWEEP and match_en
    and key_en |-> phase_out == $past(phase_src, FREQ_LAT_KEY) &&
    amp_out == $past(amp_src, FREQ_LAT_KEY)) else $error("matched delay misaligned");
  sweep_plain_a: assert property (settled_s and mode == MODE_SWEEP and !match_en
    and key_en |-> freq_out == $past(freq_src, FREQ_LAT_SWEEP_KEY) &&
    amp_out == $past(amp_src, AMP_LAT_SWEEP)) else $error("sweep delay wrong");
  sweep_phase_a: assert property (settled_s and mode == MODE_SWEEP and !match_en
    and !key_en |-> phase_out == $past(phase_src, PHASE_LAT_SWEEP)) else $error("bad phase");
  sweep_match_a: assert property (settled_s and mode == MODE_SWEEP and match_en
    and !key_en |-> phase_out == $past(phase_src, FREQ_LAT_SWEEP)) else $error("bad match");
  amp_bypass_a: assert property (!key_en ##1 !key_en |-> amp_out == AMP_FULL)
    else $error("amplitude not full scale");
  port_route_a: assert property (par_freq_s |-> ##1 freq_src == $past(port_data, 2))
    else $error("port word not captured");

endmodule // dds_tuning_latency_pipeline

// ==== port_host_model.sv ====
// Host controller model driving the parallel data port
`timescale 1ns/1ps
module port_host_model
  import dds_latency_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Requests from the bench
  input wire logic req,
  input wire logic [PORT_W-1:0] req_data,
  input wire logic [FSEL_W-1:0] req_fsel,
  input wire logic req_commit,
  input wire logic [PROF_W-1:0] req_prof,
  input wire logic [1:0] req_ramp,
  // Port pins, defined from time zero
  output logic [PORT_W-1:0] port_data = '0,
  output logic [FSEL_W-1:0] func_sel = '1, // Idle code, routes no port word
  output logic commit_strobe = 1'h0,
  output logic [PROF_W-1:0] profile_sel = '0,
  output logic ramp_direction_control = 1'h0,
  output logic ramp_pause = 1'h0
);
  logic [PROF_W-1:0] prof_want = '0; // Profile asked for, maybe not shown yet
  logic prof_hold = 1'h0; // Profile moved last period
  ////////////////////////////////////////////////////////////////////////
  // Pins move only just after the sample edge
  always @(posedge clk) begin
    commit_strobe <= req & req_commit & !srst; // One-period strobe
    if (req) begin
      port_data <= req_data;
      func_sel <= req_fsel;
      prof_want <= req_prof;
      {ramp_pause, ramp_direction_control} <= req_ramp;
    end
    // A new profile waits out a second period, so fast requests lag
    prof_hold <= 1'h0;
    if (!prof_hold && prof_want != profile_sel) begin
      profile_sel <= prof_want;
      prof_hold <= 1'h1;
    end
  end
endmodule // port_host_model

// ==== dds_tuning_latency_pipeline_bench.sv ====
// Self-checking bench for the tuning-word latency pipeline
`timescale 1ns/1ps
module dds_tuning_latency_pipeline_bench
  import dds_latency_pkg::*;
;
  logic clk = 1'h0; // 40 MHz core clock
  logic srst = 1'h1; // Held from time zero
  logic cyc = 1'h0, stb = 1'h0, we = 1'h0; // Wishbone request
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, dat_o, rd;
  logic ack;
  logic req = 1'h0, rcommit = 1'h0; // Host model requests
  logic [31:0] rdata = 32'h0;
  logic [3:0] rfsel = 4'hF;
  logic [2:0] rprof = 3'h0;
  logic [1:0] rramp = 2'h0;
  logic [31:0] pdata; // Port pins
  logic [3:0] fsel;
  logic [2:0] prof;
  logic pcommit, rdir, rpause;
  logic [31:0] fout; // Delayed words
  logic [15:0] pout;
  logic [11:0] aout;
  int seed = 44, mismatches = 0, compares = 0, cyc_n = 0, e_ack = 0;
  ////////////////////////////////////////////////////////////////////////
  dds_tuning_latency_pipeline i_dut (.clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .port_data(pdata), .func_sel(fsel), .commit_strobe(pcommit),
    .profile_sel(prof), .ramp_direction_control(rdir), .ramp_pause(rpause),
    .freq_out(fout), .phase_out(pout), .amp_out(aout));
  port_host_model i_host (.clk(clk), .srst(srst), .req(req), .req_data(rdata),
    .req_fsel(rfsel), .req_commit(rcommit), .req_prof(rprof), .req_ramp(rramp),
    .port_data(pdata), .func_sel(fsel), .commit_strobe(pcommit), .profile_sel(prof),
    .ramp_direction_control(rdir), .ramp_pause(rpause));
  ////////////////////////////////////////////////////////////////////////
  // Clock and edge index
  initial begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) cyc_n <= cyc_n + 1;
  // Expected delay of one channel
  function automatic logic [7:0] lat(input int m, input bit k, input bit mt, input int ch);
    int f, p, a;
    f = (m == 3) ? (k ? 254 : 238) : (k ? 238 : 222);
    p = mt ? f : (m == 3) ? (k ? 238 : 222) : (k ? 222 : 206);
    a = mt ? f : (m == 3) ? 94 : 78;
    return 8'(ch == 0 ? f : ch == 1 ? p : a);
  endfunction
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Classic single cycle; waits for ack under a bound
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'h1 && n < 50);
    rd = dat_o;
    e_ack = cyc_n;
    if (ack !== 1'h1) begin
      $display("[FAIL] wb_ack_o expected 1 seen %b", ack);
      mismatches++;
      final_report();
    end
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
    @(posedge clk);
  endtask
  // One request to the host model; e_ack marks the asking edge
  task automatic host(input logic [31:0] d, input logic [3:0] f, input logic c,
      input logic [2:0] p, input logic [1:0] r);
    e_ack = cyc_n;
    req <= 1'h1;
    rdata <= d;
    rfsel <= f;
    rcommit <= c;
    rprof <= p;
    rramp <= r;
    @(posedge clk);
    req <= 1'h0;
  endtask
  // Time each enabled channel's first showing of its new word
  task automatic watch(input logic [31:0] fw, input logic [15:0] pw, input logic [11:0] aw,
      input int m, input bit k, input bit mt, input int off, input logic [2:0] en);
    int t[3];
    logic [31:0] ev;
    t = '{-1, -1, -1};
    repeat (300) begin
      @(negedge clk);
      if (t[0] < 0 && fout === fw) t[0] = cyc_n - 1 - e_ack;
      if (t[1] < 0 && pout === pw) t[1] = cyc_n - 1 - e_ack;
      if (t[2] < 0 && aout === aw) t[2] = cyc_n - 1 - e_ack;
    end
    for (int ch = 0; ch < 3; ch++) begin
      if (en[ch]) begin
        ev = 32'(lat(m, k, mt, ch)) + 32'(off);
        check("channel delay", ev, 32'(t[ch]));
      end
    end
    if (!k) check("amp unkeyed", 32'hFFF, {20'h0, aout});
    @(posedge clk);
  endtask
  // Reset for three edges; outputs must sit at rest after the second
  task automatic do_reset();
    srst <= 1'h1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("freq at reset", 32'h0, fout);
    check("phase at reset", 32'h0, {16'h0, pout});
    check("amp at reset", 32'hFFF, {20'h0, aout});
    @(posedge clk);
    srst <= 1'h0;
    @(posedge clk);
    wb(1'h0, ADR_CTRL, 32'h0);
    check("ctrl at reset", 32'h0, rd);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [31:0] fw, ctl;
    logic [15:0] pw;
    logic [11:0] aw;
    int m;
    bit k, mt;
    do_reset();
    wb(1'h1, 8'h24, $random(seed));
    wb(1'h0, 8'h24, 32'h0);
    check("unmapped read", 32'h0, rd);
    // Every mode, keying and matching, committed by software
    for (int c = 0; c < 16; c++) begin
      m = c % 4;
      {mt, k} = 2'(c >> 2);
      ctl = {28'h0, mt, k, 2'(m)};
      wb(1'h1, ADR_CTRL, ctl);
      wb(1'h0, ADR_LATENCY, 32'h0);
      fw = {8'h0, lat(m, k, mt, 2), lat(m, k, mt, 1), lat(m, k, mt, 0)};
      check("latency reg", fw, rd);
      fw = $random(seed);
      pw = 16'($random(seed));
      aw = 12'($random(seed));
      wb(1'h1, ADR_FREQ, fw);
      wb(1'h1, ADR_PHASE, {16'h0, pw});
      wb(1'h1, ADR_AMP, {20'h0, aw});
      wb(1'h0, ADR_FREQ, 32'h0);
      check("freq stage", fw, rd);
      wb(1'h1, ADR_CTRL, ctl | 32'h10);
      watch(fw, pw, aw, m, k, mt, 0, {k, 2'h3});
      wb(1'h0, ADR_FREQ_OUT, 32'h0);
      check("freq out reg", fw, rd);
      $display("test mode %0d key %0d match %0d done", m, k, mt);
    end
    // Port word straight to frequency in parallel mode, keyed
    wb(1'h1, ADR_CTRL, 32'h6);
    fw = $random(seed);
    host(fw, FSEL_FREQ, 1'h0, 3'h0, 2'h0);
    watch(fw, 16'h0, 12'h0, 2, 1, 0, 3, 3'h1);
    $display("test port word done");
    // Pin commit in single tone, with profile and ramp pause pins set, ramp direction low
    wb(1'h1, ADR_CTRL, 32'h0);
    fw = $random(seed);
    pw = 16'($random(seed));
    wb(1'h1, ADR_FREQ, fw);
    wb(1'h1, ADR_PHASE, {16'h0, pw});
    host(32'h0, 4'hF, 1'h1, 3'h5, 2'h2);
    watch(fw, pw, 12'h0, 0, 0, 0, 3, 3'h3);
    wb(1'h0, ADR_STATUS, 32'h0);
    check("status pins", {20'h0, 4'hF, 3'h0, 1'h1, 1'h0, 3'h5}, rd);
    $display("test pin commit done");
    do_reset();
    $display("test second reset done");
    final_report();
  end
endmodule // dds_tuning_latency_pipeline_bench
